// [verilog/fqx_pkg.sv]
`default_nettype none
package fqx_pkg;
    // query word addresses of the extended table
    localparam logic [7:0] FQX_ADDR_FIRST = 8'h31;
    localparam logic [7:0] FQX_ADDR_LAST = 8'h45;
    localparam logic [7:0] FQX_ADDR_VER_MAJOR = 8'h34;
    localparam logic [7:0] FQX_ADDR_VER_MINOR = 8'h35;
    localparam logic [7:0] FQX_ADDR_FEAT_LO = 8'h36;
    localparam logic [7:0] FQX_ADDR_FEAT_HI = 8'h37;
    localparam logic [7:0] FQX_ADDR_SUSPEND = 8'h3a;
    localparam logic [7:0] FQX_ADDR_BLK_CAP = 8'h3b;
    localparam logic [7:0] FQX_ADDR_OTP = 8'h3f;
    localparam logic [7:0] FQX_ADDR_BURST_CFG = 8'h41;
    localparam logic [7:0] FQX_BLK_STATUS_OFS = 8'h02;
    // table contents
    localparam logic [15:0] FQX_VAL_P = 16'h0050;
    localparam logic [15:0] FQX_VAL_R = 16'h0052;
    localparam logic [15:0] FQX_VAL_I = 16'h0049;
    localparam logic [15:0] FQX_VAL_FEAT_LO = 16'h008e;
    localparam logic [15:0] FQX_VAL_FEAT_HI = 16'h0001;
    localparam logic [15:0] FQX_VAL_SUSPEND = 16'h0001;
    localparam logic [15:0] FQX_VAL_BLK_CAP = 16'h0001;
    localparam logic [15:0] FQX_VAL_VOPT = 16'h0033;
    localparam logic [15:0] FQX_VAL_OTP_AREA = 16'h0002;
    localparam logic [15:0] FQX_VAL_PAGE = 16'h0004;
    localparam logic [15:0] FQX_VAL_SYNC_FIELDS = 16'h0004;
    localparam logic [15:0] FQX_VAL_BURST2 = 16'h0000;
    localparam logic [15:0] FQX_VAL_BURST4 = 16'h0001;
    localparam logic [15:0] FQX_VAL_BURST8 = 16'h0002;
    localparam logic [15:0] FQX_VAL_BURST_CONT = 16'h0007;
    localparam logic [15:0] FQX_UPPER_ZERO = 16'h0000;
    // register map
    localparam logic [3:0] FQX_REG_CTRL = 4'h0;
    localparam logic [3:0] FQX_REG_ADDR = 4'h4;
    localparam logic [3:0] FQX_REG_DATA = 4'h8;
    localparam logic [3:0] FQX_REG_PROT = 4'hc;
    localparam int FQX_CTRL_QUERY_BIT = 0;
    localparam int FQX_CTRL_WIDE_BIT = 1;
    localparam logic [1:0] FQX_CTRL_RESET = 2'h0;
    localparam int FQX_BLOCKS = 128;
    localparam logic [31:0] FQX_UNMAPPED = 32'h0000_0000;
endpackage
`default_nettype wire

// [verilog/fqx_rom.sv]
`timescale 1ns/1ns
`default_nettype none
module fqx_rom
    import fqx_pkg::*;
(
    input wire logic [7:0] addr,
    output logic [15:0] data,
    output logic hit
);
    // version words of the extended table
    localparam logic [15:0] VERSION_CODE = 16'h0011; // arbitrary value

    // constant extended table lookup
    always_comb begin
        hit = 1'b1;
        case (addr)
            FQX_ADDR_FIRST: data = FQX_VAL_P; // RULE1
            FQX_ADDR_FIRST + 8'h01: data = FQX_VAL_R; // RULE1
            FQX_ADDR_FIRST + 8'h02: data = FQX_VAL_I; // RULE1
            FQX_ADDR_VER_MAJOR: data = VERSION_CODE;
            FQX_ADDR_VER_MINOR: data = VERSION_CODE;
            FQX_ADDR_FEAT_LO: data = FQX_VAL_FEAT_LO; // RULE3
            FQX_ADDR_FEAT_HI: data = FQX_VAL_FEAT_HI; // RULE4
            FQX_ADDR_SUSPEND: data = FQX_VAL_SUSPEND; // RULE5
            FQX_ADDR_BLK_CAP: data = FQX_VAL_BLK_CAP; // RULE6
            FQX_ADDR_BLK_CAP + 8'h02: data = FQX_VAL_VOPT;
            FQX_ADDR_BLK_CAP + 8'h03: data = FQX_VAL_VOPT;
            FQX_ADDR_OTP: data = FQX_VAL_OTP_AREA; // RULE7
            FQX_ADDR_OTP + 8'h01: data = FQX_VAL_PAGE;
            FQX_ADDR_BURST_CFG: data = FQX_VAL_SYNC_FIELDS; // RULE8
            FQX_ADDR_BURST_CFG + 8'h01: data = FQX_VAL_BURST2; // RULE8
            FQX_ADDR_BURST_CFG + 8'h02: data = FQX_VAL_BURST4; // RULE8
            FQX_ADDR_BURST_CFG + 8'h03: data = FQX_VAL_BURST8; // RULE8
            FQX_ADDR_BURST_CFG + 8'h04: data = FQX_VAL_BURST_CONT; // RULE8
            FQX_ADDR_FEAT_HI + 8'h01,
            FQX_ADDR_FEAT_HI + 8'h02,
            FQX_ADDR_BLK_CAP + 8'h01: data = 16'h0000;
            default: begin
                data = 16'h0000;
                hit = 1'b0;
            end
        endcase
    end
endmodule // fqx_rom
`default_nettype wire

// [verilog/fqx_top.sv]
// Function
// RULE1: query reads at 31h..33h return P, R, I in the low byte, zeros elsewhere.
// RULE2: in x16 the upper data lines float on query reads; in wide mode they read 0000h.
// RULE3: the first feature word reads 008Eh.
// RULE4: the second feature word reads 0001h (synchronous read supported).
// RULE5: the suspend word reads 0001h, program allowed during erase suspend.
// RULE6: the block status capability word reads 0001h.
// RULE7: the OTP protection type reads 02h, a full OTP area.
// RULE8: burst codes read 0004h, 0000h, 0001h, 0002h and 0007h at 41h..45h.
// RULE9: the host clears the status register after an error before new program or erase.
// RULE10: block base plus two reads bit 0 as the block protect state, other bits zero.
// RULE11: the table is constant, ignores writes and answers only in query mode.
//
// Local design decisions: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module fqx_top
    import fqx_pkg::*;
#(
    parameter int BLOCKS = FQX_BLOCKS
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [15:0] upper_data_lines_out,
    output logic upper_data_lines_oe
);
    // register state
    logic [1:0] ctrl_q;
    logic [23:0] qaddr_q;
    logic [BLOCKS-1:0] prot_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // bus slave sequencing state
    typedef enum {
        BUS_IDLE,
        BUS_ANSWER
    } fqx_bus_state_t;
    fqx_bus_state_t bus_state_q;
    fqx_bus_state_t bus_state_d;

    // bus handshake
    logic req;
    logic ack;

    // transfer strobes
    logic rd_start;
    logic wr_take;

    // register selects and write strobes
    logic sel_ctrl;
    logic sel_addr;
    logic sel_data;
    logic sel_prot;
    logic wr_ctrl;
    logic wr_addr;
    logic wr_prot;
    logic [6:0] wr_blk;
    logic wr_state;

    // table lookup and query decode
    logic [15:0] rom_data;
    logic rom_hit;
    logic query_mode;
    logic wide_mode;
    logic [6:0] blk_idx;
    logic blk_status_sel;
    logic blk_prot;
    logic [31:0] query_word;

    // full compare of a bus address against a register offset
    function automatic logic reg_is(input logic [3:0] addr, input logic [3:0] offset);
        reg_is = (addr == offset);
    endfunction

    // mode bits of the control register
    assign query_mode = ctrl_q[FQX_CTRL_QUERY_BIT];
    assign wide_mode = ctrl_q[FQX_CTRL_WIDE_BIT];

    // block index and block status offset taken from the query address
    assign blk_idx = qaddr_q[22:16];
    assign blk_status_sel = (qaddr_q[15:0] == {8'h00, FQX_BLK_STATUS_OFS}); // RULE10
    assign blk_prot = prot_q[blk_idx];

    // fixed extended table
    fqx_rom u_rom (
        .addr(qaddr_q[7:0]),
        .data(rom_data),
        .hit(rom_hit)
    );

    // bus slave sequencing: wait in the first cycle, answer in the second
    always_comb begin
        bus_state_d = bus_state_q;
        case (bus_state_q)
            BUS_IDLE: begin
                if (req) begin
                    bus_state_d = BUS_ANSWER;
                end
            end
            BUS_ANSWER: begin
                bus_state_d = BUS_IDLE;
            end
            default: begin
                bus_state_d = BUS_IDLE;
            end
        endcase
    end

    // sequencing state register
    always_ff @(posedge clk) begin
        if (!resetn) begin
            bus_state_q <= BUS_IDLE;
        end else begin
            bus_state_q <= bus_state_d;
        end
    end

    // handshake: waitrequest stays high until the answer cycle
    assign req = avs_read | avs_write;
    assign ack = (bus_state_q == BUS_ANSWER);
    assign avs_waitrequest = req & ~ack;

    // transfer strobes
    assign rd_start = avs_read & ~ack; // read data latched in the wait cycle
    assign wr_take = avs_write & ack & avs_byteenable[0]; // write lands on the answer edge

    // register selects
    assign sel_ctrl = reg_is(avs_address, FQX_REG_CTRL);
    assign sel_addr = reg_is(avs_address, FQX_REG_ADDR);
    assign sel_data = reg_is(avs_address, FQX_REG_DATA);
    assign sel_prot = reg_is(avs_address, FQX_REG_PROT);

    // write strobes; the data register has none, so the table stays fixed
    assign wr_ctrl = wr_take & sel_ctrl;
    assign wr_addr = wr_take & sel_addr;
    assign wr_prot = wr_take & sel_prot;
    assign wr_blk = avs_writedata[6:0];
    assign wr_state = avs_writedata[8];

    // control register: query mode and bus width
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ctrl_q <= FQX_CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_q <= avs_writedata[1:0];
        end
    end

    // query word address
    always_ff @(posedge clk) begin
        if (!resetn) begin
            qaddr_q <= 24'h000000;
        end else if (wr_addr) begin
            qaddr_q <= avs_writedata[23:0];
        end
    end

    // one protect flag per block, set or cleared by index
    for (genvar b = 0; b < BLOCKS; b++) begin : g_prot
        always_ff @(posedge clk) begin
            if (!resetn) begin
                prot_q[b] <= 1'b0;
            end else if (wr_prot && (wr_blk == 7'(b))) begin
                prot_q[b] <= wr_state; // RULE10
            end
        end
    end

    // query word, zero outside query mode
    always_comb begin
        query_word = 32'h0000_0000;
        if (query_mode) begin // RULE11
            if (blk_status_sel) begin
                query_word = {31'h0, blk_prot}; // RULE10
            end else if (rom_hit) begin
                query_word = {FQX_UPPER_ZERO, rom_data}; // RULE1 RULE2
            end
        end
    end

    // read data of the selected register
    always_comb begin
        rdata_d = FQX_UNMAPPED;
        if (sel_ctrl) begin
            rdata_d = {30'h0, ctrl_q};
        end else if (sel_addr) begin
            rdata_d = {8'h00, qaddr_q};
        end else if (sel_data) begin
            rdata_d = wide_mode ? query_word : {16'h0000, query_word[15:0]}; // RULE2
        end else if (sel_prot) begin
            rdata_d = {31'h0, blk_prot}; // RULE10
        end
    end

    // read data latched in the wait cycle, held until the next read
    always_ff @(posedge clk) begin
        if (!resetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (rd_start) begin
            rdata_q <= rdata_d;
        end
    end

    assign avs_readdata = rdata_q;

    // upper lines carry zero whenever they are driven
    always_ff @(posedge clk) begin
        if (!resetn) begin
            upper_data_lines_out <= 16'h0000;
        end else begin
            upper_data_lines_out <= FQX_UPPER_ZERO; // RULE2
        end
    end

    // upper lines driven only in wide query mode, floating in x16
    always_ff @(posedge clk) begin
        if (!resetn) begin
            upper_data_lines_oe <= 1'b0;
        end else begin
            upper_data_lines_oe <= query_mode & wide_mode; // RULE2
        end
    end
endmodule // fqx_top
`default_nettype wire

// [tb/fqx_top_checker.sv]
`timescale 1ns/1ns
`default_nettype none
module fqx_top_checker #(parameter int BLOCKS = 128) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [15:0] upper_data_lines_out,
    input wire logic upper_data_lines_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // read taken at this edge
    wire logic tk = avs_read && !avs_waitrequest;
    a_wait_first: assert property ($rose(avs_read) || $rose(avs_write) |-> avs_waitrequest)
        else $error("no wait on new request");
    a_wait_ends: assert property (avs_read && avs_waitrequest |=> !avs_waitrequest)
        else $error("wait held too long");
    a_data_holds: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
        else $error("readdata moved");
    a_upper_low: assert property (upper_data_lines_out == 16'h0000)
        else $error("upper lines not zero");
    a_unmapped_zero: assert property (tk && avs_address[1:0] != 2'h0 |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_prot_bits: assert property (tk && avs_address == 4'hc |-> avs_readdata[31:1] == 31'h0)
        else $error("protect reserved bits set");
    a_data_upper: assert property (tk && avs_address == 4'h8 |-> avs_readdata[31:8] == 24'h0)
        else $error("query word upper bits set");
    a_reset_quiet: assert property ($rose(resetn) |-> avs_readdata == 32'h0 && !upper_data_lines_oe)
        else $error("outputs not quiet after reset");
    c_query: cover property (tk && avs_address == 4'h8);
    c_prot: cover property (tk && avs_address == 4'hc && avs_readdata[0]);
    c_wide: cover property (upper_data_lines_oe);
endmodule // fqx_top_checker
bind fqx_top fqx_top_checker #(.BLOCKS(BLOCKS)) u_chk (.clk(clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .upper_data_lines_out(upper_data_lines_out), .upper_data_lines_oe(upper_data_lines_oe));
`default_nettype wire

// [tb/fqx_host_bfm.sv]
`timescale 1ns/1ns
`default_nettype none
module fqx_host_bfm (
    input wire logic clk,
    input wire logic avs_waitrequest,
    output logic [3:0] avs_address,
    output logic avs_read,
    output logic avs_write,
    output logic [31:0] avs_writedata,
    output logic [3:0] avs_byteenable
);
    logic [31:0] q[$];
    // idle bus at time zero
    initial begin
        avs_address = 4'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hf;
    end
    // one request held until waitrequest low; reads note the expected word
    // only register reads and register writes, never program or erase
    task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= w ? d : 32'h0;
        if (!w) q.push_back(d);
        do @(posedge clk); while (avs_waitrequest);
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
endmodule // fqx_host_bfm
`default_nettype wire

// [tb/fqx_top_tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module fqx_top_tb_top;
    import fqx_pkg::*;
    logic clk, resetn, wt, rd, wr, oe;
    logic [3:0] a, be;
    logic [31:0] wd, rdat;
    logic [15:0] up;
    int errors = 0, total_checks = 0, seed = 32'hcc3ce8ce;
    logic [6:0] blk;
    logic [7:0] qa [13] = '{8'h31, 8'h32, 8'h33, 8'h36, 8'h37, 8'h3a, 8'h3b, 8'h3f, 8'h41, 8'h42,
        8'h43, 8'h44, 8'h45};
    logic [15:0] qv [13] = '{16'h50, 16'h52, 16'h49, 16'h8e, 16'h1, 16'h1, 16'h1, 16'h2, 16'h4,
        16'h0, 16'h1, 16'h2, 16'h7};
    fqx_host_bfm h (.clk(clk), .avs_waitrequest(wt), .avs_address(a), .avs_read(rd),
        .avs_write(wr), .avs_writedata(wd), .avs_byteenable(be));
    fqx_top dut (.clk(clk), .resetn(resetn), .avs_address(a), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wt),
        .upper_data_lines_out(up), .upper_data_lines_oe(oe));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // watcher: oldest note against each taken read
    always @(posedge clk) if (rd && !wt) check(rdat, h.q.pop_front());
    // hang guard
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        give_verdict;
    end
    // main sequence
    initial begin
        resetn = 1'b0;
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        blk = 7'($random(seed));
        h.xfer(1'b0, FQX_REG_DATA, 32'h0);
        h.xfer(1'b1, FQX_REG_CTRL, 32'h1);
        for (int i = 0; i < 13; i++) begin
            h.xfer(1'b1, FQX_REG_ADDR, {24'h0, qa[i]});
            h.xfer(1'b0, FQX_REG_DATA, {16'h0, qv[i]});
        end
        h.xfer(1'b1, FQX_REG_DATA, 32'hffff);
        h.xfer(1'b0, FQX_REG_DATA, 32'h7);
        h.xfer(1'b1, FQX_REG_PROT, {23'h0, 1'b1, 1'b0, blk});
        h.xfer(1'b1, FQX_REG_ADDR, {9'h0, blk, 16'h0002});
        h.xfer(1'b0, FQX_REG_PROT, 32'h1);
        h.xfer(1'b0, FQX_REG_DATA, 32'h1);
        h.xfer(1'b1, FQX_REG_PROT, {25'h0, blk});
        h.xfer(1'b0, FQX_REG_DATA, 32'h0);
        h.xfer(1'b0, 4'h2, 32'h0);
        h.xfer(1'b1, FQX_REG_CTRL, 32'h3);
        repeat (2) @(posedge clk);
        check({31'h0, oe}, 32'h1);
        check({16'h0, up}, 32'h0);
        h.xfer(1'b1, FQX_REG_ADDR, {24'h0, FQX_ADDR_FIRST});
        h.xfer(1'b0, FQX_REG_DATA, {FQX_UPPER_ZERO, FQX_VAL_P});
        h.xfer(1'b0, FQX_REG_CTRL, 32'h3);
        h.xfer(1'b0, FQX_REG_ADDR, {24'h0, FQX_ADDR_FIRST});
        h.xfer(1'b1, FQX_REG_CTRL, 32'h1);
        repeat (2) @(posedge clk);
        check({31'h0, oe}, 32'h0);
        give_verdict;
    end
endmodule // fqx_top_tb_top
`default_nettype wire
